// ==== core/ovp_regs.svh ====
// Purpose: Register offsets, fields, reset values and timing for output protection.
// Assumes: 250 MHz core clock.
// Notes: Cycle counts derive from times; least times round up.
`ifndef OVP_REGS_SVH
`define OVP_REGS_SVH
`define OVP_OFS_LIMIT 16'h0040
`define OVP_OFS_RESP 16'h0041
`define OVP_OFS_FAST_ACT 16'hFE01
`define OVP_OFS_OLP_ACT 16'hFE02
`define OVP_OFS_RISE 16'hFE2F
`define OVP_OFS_FALL 16'hFE30
`define OVP_OFS_DEB 16'hFE31
`define OVP_OFS_HYST 16'hFE50
`define OVP_OFS_STATUS 16'hFE80
`define OVP_ACT_MSB 7
`define OVP_ACT_LSB 6
`define OVP_THR_MSB 6
`define OVP_DEB_MSB 1
`define OVP_ST_ACC 0
`define OVP_ST_FAST 1
`define OVP_ST_OLP 2
`define OVP_RST_LIMIT 16'h07FF
`define OVP_RST_ACT 8'hC0
`define OVP_RST_RISE 8'h7F
`define OVP_RST_FALL 8'h60
`define OVP_RST_BYTE 8'h00
`define OVP_OLP_DIFF 11'h087
`define OVP_CLK_MHZ 250
`define OVP_CLK_HZ 250000000
`define OVP_FAST_HZ 1500
`define OVP_BLANK_NS 10000
`define OVP_OLP_NS 10000
`define OVP_DEB0_NS 120
`define OVP_DEB1_NS 240
`define OVP_DEB2_NS 480
`define OVP_DEB3_NS 640
`define OVP_NS2CYC(ns) ((((ns) * `OVP_CLK_MHZ) + 999) / 1000)
`endif

// ==== core/ovp_pkg.sv ====
// Purpose: Types shared by the output protection block.
// Assumes: Nothing beyond the register header.
// Notes: Response codes map in a fixed order of our own.
package ovp_pkg;
  typedef enum logic [1:0] {
    ACT_SHUTDOWN = 2'h0,
    ACT_PWM_OFF = 2'h1,
    ACT_SOFT_START = 2'h2,
    ACT_IGNORE = 2'h3
  } ovp_action_type;
  typedef enum logic [1:0] {
    FS_ARMED = 2'h0,
    FS_TRIP_BLANK = 2'h1,
    FS_TRIPPED = 2'h3,
    FS_RESET_BLANK = 2'h2
  } ovp_fast_state_type;
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ovp_reg_req_type;
  typedef struct packed {
    logic [10:0] fb;
    logic [10:0] fast;
    logic valid;
  } ovp_sample_type;
  typedef struct packed {
    logic [15:0] limit;
    logic [7:0] resp;
    logic [7:0] fast_act;
    logic [7:0] olp_act;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] deb;
    logic [7:0] hyst;
  } ovp_regs_type;
  typedef struct packed {
    ovp_regs_type r;
    logic [15:0] rdata;
    logic [31:0] hc_sum;
    logic [19:0] hc_cnt;
    logic [31:0] fl_sum;
    logic [19:0] fl_cnt;
    logic [19:0] fl_div;
    logic [10:0] norm_fb;
    logic norm_vld;
    logic [9:0] fast_fb;
    logic fast_vld;
    logic acc_fault;
    logic acc_flag;
    ovp_fast_state_type fs;
    logic [11:0] fs_cnt;
    logic [7:0] deb_cnt;
    logic fast_flag;
    logic olp_cond;
    logic [11:0] olp_cnt;
    logic olp_flag;
    logic shutdown;
    logic pwm_off;
    logic soft_start;
    logic [6:0] dac;
  } ovp_state_type;
endpackage

// ==== core/ovp_top.sv ====
// Purpose: Output voltage averaging, accurate and fast overvoltage, open-loop check.
// Assumes: Samples, zero crossings and comparator level are synchronous to REF_CLK.
// Notes: Registers sit on a simple word port at their printed offsets.
// How it works
// - Hand normal loop 11-bit average each half-cycle.
// - Hand fast loop 10-bit average at 1.5 kHz.
// - Zero crossings delimit half-cycle; output sample average.
// - Averaged feedback above limit sets accurate flag.
// - Accurate fault triggers response from its register.
// - Disable-PWM response releases with programmed hysteresis.
// - Fast comparator accepted after selected debounce.
// - Ignore comparator 10 us after threshold switch.
// - Rising and falling thresholds from 7-bit fields.
// - Trip applies action, switches to falling threshold.
// - Fast overvoltage response chosen by 2-bit field.
// - Sense paths differing over 135 codes, about 105 mV, flag fault.
// - Open-loop fault needs 10 us persistence.
// - Open-loop response chosen by 2-bit field.
`include "ovp_regs.svh"
module ovp_top #(
  parameter int FAST_DIV = `OVP_CLK_HZ / `OVP_FAST_HZ
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Register port
  input wire ovp_pkg::ovp_reg_req_type REG_REQ,
  output logic [15:0] REG_RDATA,
  // Sense inputs
  input wire ovp_pkg::ovp_sample_type SAMPLE,
  input wire logic ZERO_CROSS,
  input wire logic FAST_CMP,
  input wire logic POWER_ON_REQUEST,
  // Loop results
  output logic [10:0] NORMAL_FB,
  output logic NORMAL_FB_VALID,
  output logic [9:0] FAST_FB,
  output logic FAST_FB_VALID,
  // Comparator threshold and fault actions
  output logic [6:0] FAST_THRESHOLD,
  output logic SHUTDOWN,
  output logic PWM_DISABLE,
  output logic SOFT_START
);
  import ovp_pkg::*;

  localparam int BLANK_CYC = `OVP_NS2CYC(`OVP_BLANK_NS);
  localparam int OLP_CYC = `OVP_NS2CYC(`OVP_OLP_NS);

  ovp_state_type s_ff, nxt_s;
  logic [10:0] hc_avg, fl_avg, diff, lim;
  logic [7:0] deb_cyc;
  logic [3:0] clr;
  logic fl_tick, acc_evt, fast_evt, olp_evt, trip;
  ovp_action_type resp, fact, oact;
  ovp_action_type nresp, nfact, noact;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.norm_vld = 1'b0;
    nxt_s.fast_vld = 1'b0;
    nxt_s.soft_start = 1'b0;
    acc_evt = 1'b0;
    fast_evt = 1'b0;
    olp_evt = 1'b0;
    trip = 1'b0;
    clr = 4'h0;
    resp = ovp_action_type'(s_ff.r.resp[`OVP_ACT_MSB:`OVP_ACT_LSB]);
    fact = ovp_action_type'(s_ff.r.fast_act[`OVP_ACT_MSB:`OVP_ACT_LSB]);
    oact = ovp_action_type'(s_ff.r.olp_act[`OVP_ACT_MSB:`OVP_ACT_LSB]);
    lim = s_ff.r.limit[10:0];
    hc_avg = (s_ff.hc_cnt != 20'h0) ? 11'(s_ff.hc_sum / 32'(s_ff.hc_cnt)) : 11'h0;
    fl_avg = (s_ff.fl_cnt != 20'h0) ? 11'(s_ff.fl_sum / 32'(s_ff.fl_cnt)) : 11'h0;
    fl_tick = (s_ff.fl_div == 20'(FAST_DIV - 1));
    diff = (SAMPLE.fb > SAMPLE.fast) ? SAMPLE.fb - SAMPLE.fast : SAMPLE.fast - SAMPLE.fb;
    case (s_ff.r.deb[`OVP_DEB_MSB:0])
      2'h0: deb_cyc = 8'(`OVP_NS2CYC(`OVP_DEB0_NS));
      2'h1: deb_cyc = 8'(`OVP_NS2CYC(`OVP_DEB1_NS));
      2'h2: deb_cyc = 8'(`OVP_NS2CYC(`OVP_DEB2_NS));
      default: deb_cyc = 8'(`OVP_NS2CYC(`OVP_DEB3_NS));
    endcase

    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        `OVP_OFS_LIMIT: nxt_s.r.limit = REG_REQ.wdata;
        `OVP_OFS_RESP: nxt_s.r.resp = REG_REQ.wdata[7:0];
        `OVP_OFS_FAST_ACT: nxt_s.r.fast_act = REG_REQ.wdata[7:0];
        `OVP_OFS_OLP_ACT: nxt_s.r.olp_act = REG_REQ.wdata[7:0];
        `OVP_OFS_RISE: nxt_s.r.rise = REG_REQ.wdata[7:0];
        `OVP_OFS_FALL: nxt_s.r.fall = REG_REQ.wdata[7:0];
        `OVP_OFS_DEB: nxt_s.r.deb = REG_REQ.wdata[7:0];
        `OVP_OFS_HYST: nxt_s.r.hyst = REG_REQ.wdata[7:0];
        `OVP_OFS_STATUS: clr = REG_REQ.wdata[3:0];
        default: clr = 4'h0;
      endcase
    end
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        `OVP_OFS_LIMIT: nxt_s.rdata = s_ff.r.limit;
        `OVP_OFS_RESP: nxt_s.rdata = {8'h00, s_ff.r.resp};
        `OVP_OFS_FAST_ACT: nxt_s.rdata = {8'h00, s_ff.r.fast_act};
        `OVP_OFS_OLP_ACT: nxt_s.rdata = {8'h00, s_ff.r.olp_act};
        `OVP_OFS_RISE: nxt_s.rdata = {8'h00, s_ff.r.rise};
        `OVP_OFS_FALL: nxt_s.rdata = {8'h00, s_ff.r.fall};
        `OVP_OFS_DEB: nxt_s.rdata = {8'h00, s_ff.r.deb};
        `OVP_OFS_HYST: nxt_s.rdata = {8'h00, s_ff.r.hyst};
        `OVP_OFS_STATUS: nxt_s.rdata = {12'h000, s_ff.fs == FS_TRIPPED, s_ff.olp_flag, s_ff.fast_flag, s_ff.acc_flag};
        default: nxt_s.rdata = 16'h0000;
      endcase
    end

    // half-cycle window closes on a zero crossing
    if (ZERO_CROSS) begin
      if (s_ff.hc_cnt != 20'h0) begin
        nxt_s.norm_fb = hc_avg;
        nxt_s.norm_vld = 1'b1;
        // hysteresis only with the disable-PWM response
        if (s_ff.acc_fault && resp == ACT_PWM_OFF) begin
          nxt_s.acc_fault = (12'(hc_avg) + 12'(s_ff.r.hyst)) > 12'(lim);
        end else begin
          nxt_s.acc_fault = hc_avg > lim;
        end
        acc_evt = nxt_s.acc_fault && !s_ff.acc_fault;
      end
      nxt_s.hc_sum = 32'h0;
      nxt_s.hc_cnt = 20'h0;
    end
    // fast window at the 1.5 kHz tick
    nxt_s.fl_div = fl_tick ? 20'h0 : s_ff.fl_div + 20'h1;
    if (fl_tick) begin
      if (s_ff.fl_cnt != 20'h0) begin
        nxt_s.fast_fb = fl_avg[10:1];
        nxt_s.fast_vld = 1'b1;
      end
      nxt_s.fl_sum = 32'h0;
      nxt_s.fl_cnt = 20'h0;
    end
    if (SAMPLE.valid) begin
      nxt_s.hc_sum = nxt_s.hc_sum + 32'(SAMPLE.fb);
      nxt_s.hc_cnt = nxt_s.hc_cnt + 20'h1;
      nxt_s.fl_sum = nxt_s.fl_sum + 32'(SAMPLE.fb);
      nxt_s.fl_cnt = nxt_s.fl_cnt + 20'h1;
      nxt_s.olp_cond = diff > `OVP_OLP_DIFF;
    end

    // debounce and blanking count core clock cycles
    nxt_s.deb_cnt = 8'h00;
    nxt_s.fs_cnt = 12'h000;
    case (s_ff.fs)
      FS_ARMED: begin
        if (FAST_CMP) begin
          nxt_s.deb_cnt = s_ff.deb_cnt + 8'h01;
          if (s_ff.deb_cnt == deb_cyc - 8'h01) begin
            // trip moves to the falling threshold
            trip = 1'b1;
            fast_evt = 1'b1;
            nxt_s.deb_cnt = 8'h00;
            nxt_s.fs = (s_ff.r.rise == s_ff.r.fall) ? FS_TRIPPED : FS_TRIP_BLANK;
          end
        end
      end
      FS_TRIP_BLANK: begin
        nxt_s.fs_cnt = s_ff.fs_cnt + 12'h001;
        if (s_ff.fs_cnt == 12'(BLANK_CYC - 1)) begin
          nxt_s.fs = FS_TRIPPED;
          nxt_s.fs_cnt = 12'h000;
        end
      end
      FS_TRIPPED: begin
        if (!FAST_CMP) begin
          nxt_s.deb_cnt = s_ff.deb_cnt + 8'h01;
          if (s_ff.deb_cnt == deb_cyc - 8'h01) begin
            nxt_s.deb_cnt = 8'h00;
            nxt_s.fs = (s_ff.r.rise == s_ff.r.fall) ? FS_ARMED : FS_RESET_BLANK;
          end
        end
      end
      FS_RESET_BLANK: begin
        // blanking after return to rising threshold
        nxt_s.fs_cnt = s_ff.fs_cnt + 12'h001;
        if (s_ff.fs_cnt == 12'(BLANK_CYC - 1)) begin
          nxt_s.fs = FS_ARMED;
          nxt_s.fs_cnt = 12'h000;
        end
      end
      default: nxt_s.fs = FS_ARMED;
    endcase
    // 7-bit thresholds drive the comparator reference
    if (nxt_s.fs == FS_ARMED || nxt_s.fs == FS_RESET_BLANK) begin
      nxt_s.dac = nxt_s.r.rise[`OVP_THR_MSB:0];
    end else begin
      nxt_s.dac = nxt_s.r.fall[`OVP_THR_MSB:0];
    end

    // condition must hold for the whole debounce
    if (s_ff.olp_cond) begin
      if (s_ff.olp_cnt != 12'(OLP_CYC)) begin
        nxt_s.olp_cnt = s_ff.olp_cnt + 12'h001;
      end
      olp_evt = (s_ff.olp_cnt == 12'(OLP_CYC - 1));
    end else begin
      nxt_s.olp_cnt = 12'h000;
    end

    // An event in the clearing cycle keeps its flag set.
    nxt_s.acc_flag = (s_ff.acc_flag && !clr[`OVP_ST_ACC]) || acc_evt;
    nxt_s.fast_flag = (s_ff.fast_flag && !clr[`OVP_ST_FAST]) || fast_evt;
    nxt_s.olp_flag = (s_ff.olp_flag && !clr[`OVP_ST_OLP]) || olp_evt;

    // The PWM-disable level uses next-cycle register values, so a rewritten action and its effect land together.
    nresp = ovp_action_type'(nxt_s.r.resp[`OVP_ACT_MSB:`OVP_ACT_LSB]);
    nfact = ovp_action_type'(nxt_s.r.fast_act[`OVP_ACT_MSB:`OVP_ACT_LSB]);
    noact = ovp_action_type'(nxt_s.r.olp_act[`OVP_ACT_MSB:`OVP_ACT_LSB]);
    nxt_s.pwm_off = (nxt_s.acc_fault && nresp == ACT_PWM_OFF) ||
                    (nxt_s.fast_flag && nfact == ACT_PWM_OFF) ||
                    (nxt_s.olp_flag && noact == ACT_PWM_OFF);
    nxt_s.soft_start = (acc_evt && resp == ACT_SOFT_START) ||
                       (fast_evt && fact == ACT_SOFT_START) ||
                       (olp_evt && oact == ACT_SOFT_START);
    // Shutdown holds until the power-on request, but a new event wins.
    if ((acc_evt && resp == ACT_SHUTDOWN) || (fast_evt && fact == ACT_SHUTDOWN) ||
        (olp_evt && oact == ACT_SHUTDOWN)) begin
      nxt_s.shutdown = 1'b1;
    end else if (POWER_ON_REQUEST) begin
      nxt_s.shutdown = 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      s_ff <= '0;
      s_ff.r.limit <= `OVP_RST_LIMIT;
      s_ff.r.resp <= `OVP_RST_ACT;
      s_ff.r.fast_act <= `OVP_RST_ACT;
      s_ff.r.olp_act <= `OVP_RST_ACT;
      s_ff.r.rise <= `OVP_RST_RISE;
      s_ff.r.fall <= `OVP_RST_FALL;
      s_ff.r.deb <= `OVP_RST_BYTE;
      s_ff.r.hyst <= `OVP_RST_BYTE;
      s_ff.fs <= FS_ARMED;
      s_ff.dac <= 7'(`OVP_RST_RISE);
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign REG_RDATA = s_ff.rdata;
  assign NORMAL_FB = s_ff.norm_fb;
  assign NORMAL_FB_VALID = s_ff.norm_vld;
  assign FAST_FB = s_ff.fast_fb;
  assign FAST_FB_VALID = s_ff.fast_vld;
  assign FAST_THRESHOLD = s_ff.dac;
  assign SHUTDOWN = s_ff.shutdown;
  assign PWM_DISABLE = s_ff.pwm_off;
  assign SOFT_START = s_ff.soft_start;

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  half_out_a: assert property (
    ZERO_CROSS && s_ff.hc_cnt != 20'h0 |=> NORMAL_FB_VALID && NORMAL_FB == $past(hc_avg))
    else $error("half-cycle result missing or wrong");
  fast_out_a: assert property (
    fl_tick && s_ff.fl_cnt != 20'h0 |=> FAST_FB_VALID && FAST_FB == $past(fl_avg[10:1]))
    else $error("fast result missing or wrong");
  window_reset_a: assert property (
    ZERO_CROSS && !SAMPLE.valid |=> s_ff.hc_cnt == 20'h0)
    else $error("half-cycle window not restarted");
  acc_trip_a: assert property (
    NORMAL_FB_VALID && NORMAL_FB > lim |-> s_ff.acc_fault && s_ff.acc_flag)
    else $error("accurate limit crossed without flag");
  acc_pwm_a: assert property (
    s_ff.acc_fault && resp == ACT_PWM_OFF |-> PWM_DISABLE)
    else $error("accurate fault did not disable PWM");
  hyst_release_a: assert property (
    $fell(s_ff.acc_fault) && $past(resp) == ACT_PWM_OFF |->
      12'(NORMAL_FB) + 12'(s_ff.r.hyst) <= 12'(lim))
    else $error("accurate fault released inside hysteresis");
  fast_deb_a: assert property (
    trip |-> s_ff.deb_cnt == deb_cyc - 8'h01 && FAST_CMP)
    else $error("fast trip before debounce");
  blank_len_a: assert property (
    s_ff.fs == FS_TRIP_BLANK && nxt_s.fs != FS_TRIP_BLANK |-> s_ff.fs_cnt == 12'(BLANK_CYC - 1))
    else $error("blanking length wrong");
  fall_thr_a: assert property (
    s_ff.fs == FS_TRIPPED |-> FAST_THRESHOLD == s_ff.r.fall[`OVP_THR_MSB:0])
    else $error("tripped without falling threshold");
  fast_shut_a: assert property (
    fast_evt && fact == ACT_SHUTDOWN |=> SHUTDOWN [*2])
    else $error("fast trip shutdown not held");
  olp_diff_a: assert property (
    SAMPLE.valid && diff > `OVP_OLP_DIFF |=> s_ff.olp_cond)
    else $error("sense difference not seen");
  olp_deb_a: assert property (
    $rose(s_ff.olp_flag) |-> $past(s_ff.olp_cnt) == 12'(OLP_CYC - 1))
    else $error("open-loop flag before debounce");
  olp_pwm_a: assert property (
    s_ff.olp_flag && oact == ACT_PWM_OFF |-> PWM_DISABLE)
    else $error("open-loop fault did not disable PWM");


  // These checks lean on internal events, state and outputs rather than on the counters they guard.
  fast_deb_run_a: assert property (
    !FAST_CMP |=> (!trip) [*8] ##1 (!trip) [*8] ##1 (!trip) [*8] ##1 (!trip) [*5])
    else $error("fast trip on a short comparator pulse");
  rise_thr_a: assert property (
    s_ff.fs == FS_ARMED || s_ff.fs == FS_RESET_BLANK |-> FAST_THRESHOLD == s_ff.r.rise[`OVP_THR_MSB:0])
    else $error("armed without rising threshold");
  acc_set_a: assert property (
    acc_evt |=> s_ff.acc_flag)
    else $error("accurate flag lost on its event");
  acc_soft_a: assert property (
    acc_evt && resp == ACT_SOFT_START |=> SOFT_START)
    else $error("accurate fault gave no soft start");
  acc_shut_a: assert property (
    acc_evt && resp == ACT_SHUTDOWN |=> SHUTDOWN)
    else $error("accurate fault gave no shutdown");
  fast_set_a: assert property (
    fast_evt |=> s_ff.fast_flag && FAST_THRESHOLD == s_ff.r.fall[`OVP_THR_MSB:0])
    else $error("fast trip without flag or falling threshold");
  fast_pwm_a: assert property (
    s_ff.fast_flag && fact == ACT_PWM_OFF |-> PWM_DISABLE)
    else $error("fast fault did not disable PWM");
  fast_soft_a: assert property (
    fast_evt && fact == ACT_SOFT_START |=> SOFT_START)
    else $error("fast trip gave no soft start");
  shut_hold_a: assert property (
    SHUTDOWN && !POWER_ON_REQUEST |=> SHUTDOWN)
    else $error("shutdown released without power-on request");
  olp_set_a: assert property (
    olp_evt |=> s_ff.olp_flag)
    else $error("open-loop flag lost on its event");
  olp_shut_a: assert property (
    olp_evt && oact == ACT_SHUTDOWN |=> SHUTDOWN)
    else $error("open-loop fault gave no shutdown");

  trip_c: cover property (trip ##[1:1000] s_ff.fs == FS_TRIP_BLANK);
  acc_c: cover property ($rose(s_ff.acc_flag));
  olp_c: cover property ($rose(s_ff.olp_flag));
  soft_c: cover property (SOFT_START);
  shut_c: cover property ($rose(SHUTDOWN));
endmodule

// ==== testbench/ovp_stage_model.sv ====
// Purpose: Boost stage sense dividers, sense converter and fast comparator stand-in.
// Assumes: 11-bit codes span 0 V to 1.6 V; the threshold code spans 1 V to 1.5 V.
// Notes: Outputs move 1 ns after the clock edge; stale sample fields are inverted.
module ovp_stage_model (
  // Clock
  input wire logic clk,
  // Commanded levels
  input wire logic [10:0] fb_code,
  input wire logic [10:0] fast_code,
  input wire logic smp_en,
  input wire logic [6:0] thr,
  // Sense outputs
  output ovp_pkg::ovp_sample_type sample,
  output logic cmp
);
  timeunit 1ns;
  timeprecision 100ps;
  import ovp_pkg::*;
  int mv;
  int thr_mv;
  initial begin
    sample = '0;
    cmp = 1'b0;
  end
  always @(posedge clk) begin
    mv = int'(fast_code) * 1600 / 2048;
    thr_mv = 1000 + int'(thr) * 500 / 127;
    sample.valid <= #1 smp_en;
    sample.fb <= #1 smp_en ? fb_code : ~sample.fb;
    sample.fast <= #1 smp_en ? fast_code : ~sample.fast;
    cmp <= #1 (mv > thr_mv);
  end
endmodule

// ==== testbench/output_voltage_protection_tb_top.sv ====
// Purpose: Self-checking bench for averaging, overvoltage and open-loop checks.
// Assumes: FAST_DIV shortened to 40; blanking and open-loop counts are 2500 cycles.
// Notes: Every drive happens 1 ns after a rising edge.
module output_voltage_protection_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import ovp_pkg::*;
  localparam logic [15:0] ST = 16'hFE80;
  localparam logic [15:0] OFS [8] = '{16'h0040, 16'h0041, 16'hFE01, 16'hFE02, 16'hFE2F, 16'hFE30, 16'hFE31, 16'hFE50};
  localparam logic [15:0] RSTV [8] = '{16'h07FF, 16'h00C0, 16'h00C0, 16'h00C0, 16'h007F, 16'h0060, 16'h0000, 16'h0000};
  localparam int DEB [4] = '{30, 60, 120, 160};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ovp_reg_req_type req = '0;
  logic [15:0] rdata;
  ovp_sample_type sample;
  logic zc = 1'b0;
  logic cmp;
  logic por = 1'b0;
  logic [10:0] nfb;
  logic nvld;
  logic [9:0] ffb;
  logic fvld;
  logic [6:0] thr;
  logic shdn;
  logic pwm;
  logic ss;
  logic [10:0] fb_code = '0;
  logic [10:0] fast_code = '0;
  logic smp_en = 1'b0;
  logic ss_seen = 1'b0;
  int errors = 0;
  int tests_run = 0;

  ovp_top #(.FAST_DIV(40)) u_dut (
    .REF_CLK(clk), .RST_N(rst_n), .REG_REQ(req), .REG_RDATA(rdata), .SAMPLE(sample),
    .ZERO_CROSS(zc), .FAST_CMP(cmp), .POWER_ON_REQUEST(por), .NORMAL_FB(nfb), .NORMAL_FB_VALID(nvld),
    .FAST_FB(ffb), .FAST_FB_VALID(fvld), .FAST_THRESHOLD(thr), .SHUTDOWN(shdn), .PWM_DISABLE(pwm),
    .SOFT_START(ss));
  ovp_stage_model u_stage (
    .clk(clk), .fb_code(fb_code), .fast_code(fast_code), .smp_en(smp_en), .thr(thr),
    .sample(sample), .cmp(cmp));

  initial forever #2 clk = ~clk;
  // A one-cycle pulse is caught here so tasks may look after the fact.
  always @(posedge clk) if (ss === 1'b1) ss_seen = 1'b1;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk) #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    tick(1);
    req = '0;
    tick(1);
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    req = '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    tick(1);
    req = '0;
    tick(1);
    d = rdata;
  endtask
  task automatic end_of_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_regs();
    logic [15:0] v;
    chk("thr", 16'h007F, 16'(thr));
    chk("outs", 16'h0000, {13'h0, shdn, pwm, ss});
    for (int i = 0; i < 8; i++) begin
      rd(OFS[i], v);
      chk("reset", RSTV[i], v);
      wr(OFS[i], 16'h005A);
      rd(OFS[i], v);
      chk("rw", 16'h005A, v);
      wr(OFS[i], RSTV[i]);
    end
    wr(16'h0042, 16'h00FF);
    rd(16'h0042, v);
    chk("unmapped", 16'h0000, v);
  endtask
  // Sends n samples b, b+1, ... then closes the half cycle.
  task automatic win(input int n, input logic [10:0] b);
    for (int i = 0; i < n; i++) begin
      fb_code = b + 11'(i);
      smp_en = 1'b1;
      tick(1);
    end
    smp_en = 1'b0;
    tick(2);
    zc = 1'b1;
    tick(1);
    zc = 1'b0;
    chk("nvld", 16'(n > 0), 16'(nvld));
    if (n > 0) chk("nfb", 16'(int'(b) + (n - 1) / 2), 16'(nfb));
    tick(1);
    chk("nvld_end", 16'h0000, 16'(nvld));
  endtask
  task automatic t_acc();
    logic [15:0] v;
    win(3, 11'd100);
    win(2, 11'd100);
    win(0, 11'd0);
    wr(16'h0040, 16'h0100);
    wr(16'h0041, 16'h0040);
    wr(16'h0050 | 16'hFE00, 16'h0010);
    win(1, 11'h100);
    chk("acc_eq", 16'h0000, 16'(pwm));
    win(1, 11'h101);
    chk("acc_on", 16'h0001, 16'(pwm));
    rd(ST, v);
    chk("acc_flag", 16'h0001, v);
    win(1, 11'h0F1);
    chk("acc_hyst", 16'h0001, 16'(pwm));
    win(1, 11'h0F0);
    chk("acc_off", 16'h0000, 16'(pwm));
    wr(ST, 16'h0007);
    wr(16'h0041, 16'h0000);
    win(1, 11'h101);
    chk("acc_shdn", 16'h0001, 16'(shdn));
    por = 1'b1;
    tick(2);
    chk("acc_por", 16'h0000, 16'(shdn));
    por = 1'b0;
    win(1, 11'h0F0);
    wr(16'h0041, 16'h0080);
    ss_seen = 1'b0;
    win(1, 11'h101);
    chk("acc_ss", 16'h0001, 16'({shdn, ss_seen}));
    wr(16'h0041, 16'h00C0);
    wr(ST, 16'h0007);
  endtask
  task automatic t_fast();
    logic [15:0] v;
    wr(16'hFE2F, 16'h0040);
    wr(16'hFE30, 16'h0030);
    for (int k = 0; k < 4; k++) begin
      wr(16'hFE31, 16'(k));
      wr(16'hFE01, 16'(k << 6));
      wr(ST, 16'h0007);
      ss_seen = 1'b0;
      fast_code = 11'h7D0;
      tick(DEB[k]);
      chk("deb_early", 16'h0040, 16'(thr));
      tick(2);
      chk("trip_thr", 16'h0030, 16'(thr));
      chk("act", 16'({k == 0, k == 1, k == 2}), 16'({shdn, pwm, ss_seen}));
      fast_code = 11'h000;
      tick(1000);
      chk("blank", 16'h0030, 16'(thr));
      tick(1510 + DEB[k]);
      chk("rearm_thr", 16'h0040, 16'(thr));
      rd(ST, v);
      chk("fast_flag", 16'h0001, 16'(v[1]));
      if (k == 1) begin
        wr(ST, 16'h0002);
        chk("pwm_clr", 16'h0000, 16'(pwm));
      end
      if (k == 0) begin
        por = 1'b1;
        tick(2);
        chk("fast_por", 16'h0000, 16'(shdn));
        por = 1'b0;
      end
      tick(2600);
    end
  endtask
  task automatic t_olp();
    logic [15:0] v;
    int n;
    wr(16'hFE02, 16'h0080);
    wr(ST, 16'h0007);
    fb_code = 11'd500;
    fast_code = 11'd635;
    smp_en = 1'b1;
    for (int j = 0; j < 2; j++) begin
      n = 0;
      tick(1);
      while (fvld !== 1'b1 && n < 100) begin
        tick(1);
        n++;
      end
    end
    chk("fast_fb", 16'd250, 16'(ffb));
    chk("fast_gap", 16'd39, 16'(n));
    tick(2700);
    rd(ST, v);
    chk("olp_edge", 16'h0000, 16'(v[2]));
    ss_seen = 1'b0;
    fast_code = 11'd636;
    tick(2400);
    rd(ST, v);
    chk("olp_early", 16'h0000, 16'(v[2]));
    tick(215);
    rd(ST, v);
    chk("olp_flag", 16'h0001, 16'(v[2]));
    chk("olp_act", 16'h0001, 16'(ss_seen));
    wr(16'hFE02, 16'h0040);
    chk("olp_pwm", 16'h0001, 16'(pwm));
    wr(ST, 16'h0004);
    chk("olp_clr", 16'h0000, 16'(pwm));
    smp_en = 1'b0;
  endtask

  initial begin
    #240000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick(1);
    t_regs();
    t_acc();
    t_fast();
    t_olp();
    end_of_test();
  end
endmodule
